// >>> logic/thermal_alarm_monitor.sv
// Our own choices: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
module thermal_alarm_monitor #(
    parameter int unsigned CONV_INTERVAL_CYCLES = thermal_alarm_pkg::CONV_INTERVAL_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic conv_start,
    input wire thermal_alarm_pkg::conv_result_t conv_result,
    output logic over_temp_alarm_output
);

    localparam int CW = $clog2(CONV_INTERVAL_CYCLES + 1);
    localparam logic [CW-1:0] RELOAD = CW'(CONV_INTERVAL_CYCLES - 1);

    // ---------------- bus slave ----------------
    logic acc;
    logic rd_acc;
    logic mapped;
    logic dp_write;
    logic next_dp_write;
    logic [2:0] dp_idx;
    logic [2:0] next_dp_idx;
    logic [31:0] next_hrdata;
    logic [31:0] read_mux;

    // register state
    logic [7:0] conf;
    logic [7:0] next_conf;
    logic [8:0] tos;
    logic [8:0] next_tos;
    logic [8:0] hyst;
    logic [8:0] next_hyst;
    logic [10:0] temp_result;
    logic [10:0] next_temp_result;
    logic result_valid;
    logic next_result_valid;

    // conversion scheduler state
    thermal_alarm_pkg::conv_state_t state;
    thermal_alarm_pkg::conv_state_t next_state;
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_conv_start;

    // alarm state
    logic alarm_active;
    logic next_alarm_active;
    logic look_low;
    logic next_look_low;
    logic [2:0] fault_cnt;
    logic [2:0] next_fault_cnt;
    logic next_alarm_out;

    // decoded controls and events
    logic shutdown;
    logic int_mode;
    logic polarity;
    logic [2:0] fault_limit;
    logic eval;
    logic shutdown_entry;
    logic signed [8:0] new_t9;
    logic upper_fault;
    logic lower_fault;
    logic want;

    assign shutdown = conf[thermal_alarm_pkg::CFG_SHUTDOWN_BIT];
    assign int_mode = conf[thermal_alarm_pkg::CFG_INT_MODE_BIT];
    assign polarity = conf[thermal_alarm_pkg::CFG_POLARITY_BIT];

    // zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    assign acc = hsel && htrans[1] && hready;
    assign rd_acc = acc && !hwrite;
    assign mapped = (haddr[31:5] == 27'h0000000) && (haddr[1:0] == 2'h0)
        && (haddr[4:2] <= thermal_alarm_pkg::IDX_STATUS);

    // read mux picked in the address phase so hrdata comes from a flop
    // limits and config are taken from the next values, so a read right behind
    // a write to the same register sees the new word instead of a stale one
    always_comb begin
        case (haddr[4:2])
            thermal_alarm_pkg::IDX_TEMP: begin
                read_mux = {16'h0000, temp_result, 5'h00};
            end
            thermal_alarm_pkg::IDX_CONF: begin
                read_mux = {24'h000000, next_conf};
            end
            thermal_alarm_pkg::IDX_HYST: begin
                read_mux = {16'h0000, next_hyst, 7'h00};
            end
            thermal_alarm_pkg::IDX_TOS: begin
                read_mux = {16'h0000, next_tos, 7'h00};
            end
            thermal_alarm_pkg::IDX_STATUS: begin
                read_mux = {28'h0000000, look_low, alarm_active,
                    state == thermal_alarm_pkg::ST_CONVERT, result_valid};
            end
            default: begin
                read_mux = 32'h00000000;
            end
        endcase
    end

    // address phase capture; unmapped reads return zero, writes dropped
    always_comb begin
        next_dp_write = acc && hwrite && mapped;
        next_dp_idx = haddr[4:2];
        next_hrdata = hrdata;
        if (rd_acc) begin
            next_hrdata = mapped ? read_mux : 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_idx <= 3'h0;
            hrdata <= 32'h00000000;
        end else begin
            dp_write <= next_dp_write;
            dp_idx <= next_dp_idx;
            hrdata <= next_hrdata;
        end
    end

    // data phase writes; bus stays live in every mode
    always_comb begin
        next_conf = conf;
        next_tos = tos;
        next_hyst = hyst;
        if (dp_write) begin
            case (dp_idx)
                thermal_alarm_pkg::IDX_CONF: next_conf = hwdata[7:0];
                thermal_alarm_pkg::IDX_HYST: next_hyst = hwdata[15:7];
                thermal_alarm_pkg::IDX_TOS: next_tos = hwdata[15:7];
                default: next_conf = conf;
            endcase
        end
    end

    // power-up defaults: normal, 80 C, 75 C, active low, one fault
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conf <= thermal_alarm_pkg::CONF_RESET;
            tos <= thermal_alarm_pkg::TOS_RESET;
            hyst <= thermal_alarm_pkg::HYST_RESET;
        end else begin
            conf <= next_conf;
            tos <= next_tos;
            hyst <= next_hyst;
        end
    end

    // ---------------- conversion scheduler ----------------
    // a late converter simply delays the next start; starts never overlap
    assign shutdown_entry = shutdown && (state != thermal_alarm_pkg::ST_SHUTDOWN);
    assign eval = (state == thermal_alarm_pkg::ST_CONVERT) && conv_result.done && !shutdown;

    always_comb begin
        next_state = state;
        next_cnt = (cnt != '0) ? cnt - CW'(1) : cnt;
        next_conv_start = 1'b0;
        next_temp_result = temp_result;
        next_result_valid = result_valid;
        case (state)
            thermal_alarm_pkg::ST_SHUTDOWN: begin
                next_cnt = '0;
                if (!shutdown) begin
                    next_state = thermal_alarm_pkg::ST_WAIT;
                end
            end
            thermal_alarm_pkg::ST_CONVERT: begin
                if (shutdown) begin
                    next_state = thermal_alarm_pkg::ST_SHUTDOWN;
                end else if (conv_result.done) begin
                    next_temp_result = conv_result.data;
                    next_result_valid = 1'b1;
                    next_state = thermal_alarm_pkg::ST_WAIT;
                end
            end
            thermal_alarm_pkg::ST_WAIT: begin
                if (shutdown) begin
                    next_state = thermal_alarm_pkg::ST_SHUTDOWN;
                end else if (cnt == '0) begin
                    next_conv_start = 1'b1;
                    next_cnt = RELOAD;
                    next_state = thermal_alarm_pkg::ST_CONVERT;
                end
            end
            default: begin
                next_state = thermal_alarm_pkg::ST_WAIT;
            end
        endcase
    end

    // reset lands in wait with zero count, so the first start follows at once
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= thermal_alarm_pkg::ST_WAIT;
            cnt <= '0;
            conv_start <= 1'b0;
            temp_result <= thermal_alarm_pkg::RESULT_RESET;
            result_valid <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            conv_start <= next_conv_start;
            temp_result <= next_temp_result;
            result_valid <= next_result_valid;
        end
    end

    // ---------------- alarm logic ----------------
    always_comb begin
        case (conf[thermal_alarm_pkg::CFG_QUEUE_LSB +: 2])
            2'h0: fault_limit = thermal_alarm_pkg::QUEUE_LEN_0;
            2'h1: fault_limit = thermal_alarm_pkg::QUEUE_LEN_1;
            2'h2: fault_limit = thermal_alarm_pkg::QUEUE_LEN_2;
            default: fault_limit = thermal_alarm_pkg::QUEUE_LEN_3;
        endcase
    end

    // only the upper nine result bits meet the nine-bit limits
    assign new_t9 = conv_result.data[10:2];
    assign upper_fault = new_t9 > $signed(tos);
    assign lower_fault = new_t9 < $signed(hyst);

    // which limit is being watched now
    always_comb begin
        if (int_mode) begin
            want = look_low ? lower_fault : upper_fault;
        end else begin
            want = alarm_active ? lower_fault : upper_fault;
        end
    end

    // clears are applied first so a trip in the same cycle wins
    always_comb begin
        next_alarm_active = alarm_active;
        next_look_low = look_low;
        next_fault_cnt = fault_cnt;
        // comparator mode never clears here, so reads and shutdown keep its level
        if (int_mode && (rd_acc || shutdown_entry)) begin
            next_alarm_active = 1'b0;
        end
        if (eval) begin
            if (int_mode && alarm_active) begin
                next_fault_cnt = 3'h0;
            end else if (want) begin
                if (3'(fault_cnt + 3'h1) >= fault_limit) begin
                    next_fault_cnt = 3'h0;
                    if (int_mode) begin
                        next_alarm_active = 1'b1;
                        next_look_low = !look_low;
                    end else begin
                        next_alarm_active = !alarm_active;
                    end
                end else begin
                    next_fault_cnt = 3'(fault_cnt + 3'h1);
                end
            end else begin
                next_fault_cnt = 3'h0;
            end
        end
    end

    // polarity comes from the next config so a polarity write moves the pin at the same edge
    assign next_alarm_out = next_conf[thermal_alarm_pkg::CFG_POLARITY_BIT] ? next_alarm_active
        : !next_alarm_active;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            alarm_active <= 1'b0;
            look_low <= 1'b0;
            fault_cnt <= 3'h0;
            over_temp_alarm_output <= 1'b1;
        end else begin
            alarm_active <= next_alarm_active;
            look_low <= next_look_low;
            fault_cnt <= next_fault_cnt;
            over_temp_alarm_output <= next_alarm_out;
        end
    end

    // ---------------- checks ----------------
    property p_load_result;
        @(posedge hclk) disable iff (!hresetn)
        eval |=> (temp_result == $past(conv_result.data)) && result_valid;
    endproperty
    a_load_result: assert property (p_load_result) else $error("result not loaded");

    property p_no_start_shutdown;
        @(posedge hclk) disable iff (!hresetn)
        shutdown ##1 shutdown |-> !conv_start && $stable(temp_result);
    endproperty
    a_no_start_shutdown: assert property (p_no_start_shutdown) else $error("shutdown active");

    property p_read_keeps_conv;
        @(posedge hclk) disable iff (!hresetn)
        rd_acc && state == thermal_alarm_pkg::ST_CONVERT && !conv_result.done && !shutdown
        |=> state == thermal_alarm_pkg::ST_CONVERT;
    endproperty
    a_read_keeps_conv: assert property (p_read_keeps_conv) else $error("read upset conversion");

    property p_restart;
        @(posedge hclk) disable iff (!hresetn)
        state == thermal_alarm_pkg::ST_SHUTDOWN && !shutdown |-> ##[2:3] conv_start;
    endproperty
    a_restart: assert property (p_restart) else $error("no start after shutdown");

    property p_comp_hold;
        @(posedge hclk) disable iff (!hresetn)
        !int_mode && !eval |=> $stable(alarm_active);
    endproperty
    a_comp_hold: assert property (p_comp_hold) else $error("comparator alarm moved");

    property p_read_clear;
        @(posedge hclk) disable iff (!hresetn)
        int_mode && rd_acc && !eval |=> !alarm_active;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_shutdown_clear;
        @(posedge hclk) disable iff (!hresetn)
        int_mode && shutdown_entry |=> !alarm_active;
    endproperty
    a_shutdown_clear: assert property (p_shutdown_clear) else $error("shutdown kept alarm");

    property p_queue;
        @(posedge hclk) disable iff (!hresetn)
        $rose(alarm_active) |-> $past(eval) && ($past(fault_cnt) == $past(fault_limit) - 3'h1);
    endproperty
    a_queue: assert property (p_queue) else $error("alarm before fault count");

    property p_polarity;
        @(posedge hclk) disable iff (!hresetn)
        ##1 over_temp_alarm_output == (polarity ? alarm_active : !alarm_active);
    endproperty
    a_polarity: assert property (p_polarity) else $error("alarm level wrong");

    property p_valid_first;
        @(posedge hclk) disable iff (!hresetn)
        $rose(result_valid) |-> $past(eval);
    endproperty
    a_valid_first: assert property (p_valid_first) else $error("valid without conversion");

    // a start request is a single-cycle pulse
    property p_start_pulse;
        @(posedge hclk) disable iff (!hresetn)
        conv_start |=> !conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");

    // an interrupt alarm only drops on a read or on entering shutdown
    property p_int_hold;
        @(posedge hclk) disable iff (!hresetn)
        int_mode && alarm_active && !rd_acc && !shutdown_entry |=> alarm_active;
    endproperty
    a_int_hold: assert property (p_int_hold) else $error("interrupt alarm dropped");

    // a conversion that misses the watched limit restarts the fault count
    property p_fault_restart;
        @(posedge hclk) disable iff (!hresetn)
        eval && !want |=> fault_cnt == 3'h0;
    endproperty
    a_fault_restart: assert property (p_fault_restart) else $error("fault count kept");

endmodule : thermal_alarm_monitor

// >>> logic/thermal_alarm_pkg.sv
// What this block does
// - normal mode converts every 100 ms, loads result
// - result is 11-bit two's complement, 0.125 C
// - result readable anytime, reads never disturb conversion
// - shutdown: idle, no conversions, result kept
// - bus keeps working in shutdown
// - config bit 0 picks normal or shutdown
// - convert at power-up and on leaving shutdown
// - each normal conversion compared against the one limit being watched
// - 9-bit limits, compare upper 9 result bits
// - config bit 1 mode, bits 4:3 fault filter
// - comparator: set above upper, clear below lower
// - comparator: reads or shutdown keep alarm level
// - interrupt: first trip on upper, then holds
// - interrupt: any register read clears alarm
// - interrupt: trips alternate upper then lower
// - interrupt: entering shutdown clears alarm
// - alarm needs programmed consecutive fault count
// - config bit 2 selects alarm active level
// - reset: normal, 80 C, 75 C, low, one
// - result not valid before first conversion ends
// - fault field 0..3 means 1,2,4,6 faults
// - polarity one is active high, zero low
// - mode bit one interrupt, zero comparator
// - shutdown bit one shutdown, zero normal
package thermal_alarm_pkg;

    // conversion timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned CONV_INTERVAL_MS = 100;
    localparam int unsigned CONV_INTERVAL_CYCLES = CONV_INTERVAL_MS * 1000 * CLK_MHZ;

    // data widths
    localparam int unsigned RESULT_W = 11;
    localparam int unsigned LIMIT_W = 9;
    localparam int unsigned RESULT_LSB = 5;
    localparam int unsigned LIMIT_LSB = 7;

    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_TEMP = 3'h0;
    localparam logic [2:0] IDX_CONF = 3'h1;
    localparam logic [2:0] IDX_HYST = 3'h2;
    localparam logic [2:0] IDX_TOS = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;

    // configuration field positions
    localparam int unsigned CFG_SHUTDOWN_BIT = 0;
    localparam int unsigned CFG_INT_MODE_BIT = 1;
    localparam int unsigned CFG_POLARITY_BIT = 2;
    localparam int unsigned CFG_QUEUE_LSB = 3;

    // status field positions
    localparam int unsigned STAT_VALID_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 1;
    localparam int unsigned STAT_ALARM_BIT = 2;
    localparam int unsigned STAT_LOOK_LOW_BIT = 3;

    // values after reset
    localparam logic [7:0] CONF_RESET = 8'h00;
    localparam logic [8:0] TOS_RESET = 9'h0a0;
    localparam logic [8:0] HYST_RESET = 9'h096;
    localparam logic [10:0] RESULT_RESET = 11'h000;

    // consecutive-fault counts per field code
    localparam logic [2:0] QUEUE_LEN_0 = 3'h1;
    localparam logic [2:0] QUEUE_LEN_1 = 3'h2;
    localparam logic [2:0] QUEUE_LEN_2 = 3'h4;
    localparam logic [2:0] QUEUE_LEN_3 = 3'h6;

    typedef enum logic [2:0] {
        ST_SHUTDOWN = 3'b001,
        ST_CONVERT = 3'b010,
        ST_WAIT = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic done;
        logic [10:0] data;
    } conv_result_t;

endpackage : thermal_alarm_pkg

// >>> bench/temp_converter_model.sv
`timescale 1ns/10ps
// converter stand-in: answers each start after a set delay with the bench's temperature
module temp_converter_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic conv_start,
    input wire logic [10:0] temp,
    input wire logic [7:0] latency,
    output thermal_alarm_pkg::conv_result_t conv_result
);
    logic busy;
    logic [7:0] cnt;

    // data churns every cycle outside done, so a stale capture cannot match by luck
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy <= 1'b0;
            cnt <= 8'h00;
            conv_result <= '0;
        end else begin
            conv_result.done <= 1'b0;
            conv_result.data <= ~conv_result.data;
            if (conv_start) begin
                busy <= 1'b1;
                cnt <= latency;
            end else if (busy && cnt <= 8'h01) begin
                busy <= 1'b0;
                conv_result.done <= 1'b1;
                conv_result.data <= temp;
            end else if (busy) begin
                cnt <= cnt - 8'h01;
            end
        end
    end
endmodule : temp_converter_model

// >>> bench/thermal_alarm_monitor_tb_top.sv
`timescale 1ns/10ps
module thermal_alarm_monitor_tb_top;
    localparam int unsigned INTERVAL = 50;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, conv_start, over_temp_alarm_output;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [10:0] temp;
    thermal_alarm_pkg::conv_result_t conv_result;
    int errors, n_compared, n_starts;
    int qlen[4] = '{1, 2, 4, 6};

    thermal_alarm_monitor #(.CONV_INTERVAL_CYCLES(INTERVAL)) i_thermal_alarm_monitor (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .conv_start(conv_start),
        .conv_result(conv_result), .over_temp_alarm_output(over_temp_alarm_output));

    temp_converter_model i_temp_converter_model (
        .hclk(hclk), .hresetn(hresetn), .conv_start(conv_start), .temp(temp),
        .latency(8'h0a), .conv_result(conv_result));

    // 250 MHz clock
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // counts conversion requests for the shutdown checks
    always @(posedge hclk) begin
        if (conv_start === 1'b1) n_starts++;
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task check_alarm(input logic exp);
        check("alarm", {31'h0, over_temp_alarm_output}, {31'h0, exp});
    endtask : check_alarm

    task do_reset(input logic [10:0] t);
        @(posedge hclk);
        hresetn <= 1'b0;
        temp <= t;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
    endtask : do_reset

    // one single word transfer; read data lands in rd
    task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : ahb

    // waits for n finished conversions, then lets the outputs settle
    task wait_conv(input int n);
        repeat (n) @(posedge hclk iff conv_result.done === 1'b1);
        repeat (2) @(posedge hclk);
    endtask : wait_conv

    task t_regs;
        int n;
        do_reset(11'h0c8);
        ahb(1'b0, 32'h00, 32'h0);
        check("temp early", rd, 32'h0);
        check("hresp", {31'h0, hresp}, 32'h0);
        ahb(1'b0, 32'h10, 32'h0);
        check("status early", rd, 32'h2);
        ahb(1'b0, 32'h04, 32'h0);
        check("conf", rd, 32'h0);
        ahb(1'b0, 32'h08, 32'h0);
        check("hyst", rd, 32'h4b00);
        ahb(1'b0, 32'h0c, 32'h0);
        check("tos", rd, 32'h5000);
        check_alarm(1'b1);
        ahb(1'b1, 32'h00, 32'hffff);
        wait_conv(1);
        ahb(1'b0, 32'h00, 32'h0);
        check("temp 25", rd, 32'h1900);
        ahb(1'b0, 32'h10, 32'h0);
        check("status valid", rd, 32'h1);
        ahb(1'b1, 32'h0c, 32'hffff);
        ahb(1'b0, 32'h0c, 32'h0);
        check("tos bits", rd, 32'hff80);
        ahb(1'b0, 32'h14, 32'h0);
        check("unmapped", rd, 32'h0);
        @(posedge hclk iff conv_start === 1'b1);
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (conv_start !== 1'b1 && n < 200);
        check("interval", n, INTERVAL);
        temp <= 11'h7f8;
        ahb(1'b0, 32'h00, 32'h0);
        check("temp mid", rd, 32'h1900);
        wait_conv(1);
        ahb(1'b0, 32'h00, 32'h0);
        check("temp neg", rd, 32'hff00);
        $display("t_regs done");
    endtask : t_regs

    task t_comparator;
        do_reset(11'h280);
        wait_conv(1);
        check_alarm(1'b1);
        temp <= 11'h284;
        wait_conv(1);
        check_alarm(1'b0);
        ahb(1'b0, 32'h00, 32'h0);
        check("temp hot", rd, 32'h5080);
        check_alarm(1'b0);
        ahb(1'b1, 32'h04, 32'h1);
        repeat (3) @(posedge hclk);
        check_alarm(1'b0);
        temp <= 11'h0c8;
        n_starts = 0;
        repeat (3 * INTERVAL) @(posedge hclk);
        check("starts off", n_starts, 0);
        ahb(1'b0, 32'h00, 32'h0);
        check("temp kept", rd, 32'h5080);
        ahb(1'b1, 32'h08, 32'h3c00);
        ahb(1'b0, 32'h08, 32'h0);
        check("hyst off", rd, 32'h3c00);
        ahb(1'b1, 32'h04, 32'h0);
        repeat (4) @(posedge hclk);
        check("restart", n_starts, 1);
        wait_conv(1);
        check_alarm(1'b1);
        $display("t_comparator done");
    endtask : t_comparator

    task t_interrupt;
        do_reset(11'h0c8);
        ahb(1'b1, 32'h04, 32'h6);
        temp <= 11'h2d0;
        repeat (2) @(posedge hclk);
        check_alarm(1'b0);
        wait_conv(1);
        check_alarm(1'b1);
        wait_conv(1);
        check_alarm(1'b1);
        ahb(1'b0, 32'h04, 32'h0);
        check_alarm(1'b0);
        wait_conv(2);
        check_alarm(1'b0);
        temp <= 11'h760;
        wait_conv(1);
        check_alarm(1'b1);
        ahb(1'b0, 32'h10, 32'h0);
        check("status trip", rd, 32'h5);
        check_alarm(1'b0);
        temp <= 11'h2d0;
        wait_conv(1);
        check_alarm(1'b1);
        ahb(1'b1, 32'h04, 32'h7);
        repeat (3) @(posedge hclk);
        check_alarm(1'b0);
        $display("t_interrupt done");
    endtask : t_interrupt

    task t_queue;
        for (int i = 0; i < 4; i++) begin
            do_reset(11'h2d0);
            ahb(1'b1, 32'h04, {27'h0, i[1:0], 3'h0});
            if (qlen[i] > 1) begin
                wait_conv(qlen[i] - 1);
                check_alarm(1'b1);
            end
            wait_conv(1);
            check_alarm(1'b0);
        end
        do_reset(11'h0c8);
        ahb(1'b1, 32'h04, 32'h18);
        temp <= 11'h2d0;
        wait_conv(4);
        temp <= 11'h0c8;
        wait_conv(1);
        temp <= 11'h2d0;
        wait_conv(5);
        check_alarm(1'b1);
        wait_conv(1);
        check_alarm(1'b0);
        $display("t_queue done");
    endtask : t_queue

    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test

    // main sequence; all inputs defined at time zero
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        temp = 11'h0c8;
        t_regs();
        t_comparator();
        t_interrupt();
        t_queue();
        finish_test();
    end

    // run needs about 1700 cycles; a hang is cut at 20000
    initial begin
        #80000;
        errors++;
        finish_test();
    end
endmodule : thermal_alarm_monitor_tb_top
